// >>> logic/tank_bus_responder.sv
// Poll responder of the tank gauging field bus: address match, delayed
// reply of encoded level/temperature pairs, relay and self-test control.
// Assumes frame decoding upstream on CLOCK; test result lines are async.
`timescale 1ns/1ps

module tank_bus_responder #(
    parameter int TICK_CYCLES = tank_bus_pkg::TICK_CYCLES_DEF
) (
    input wire logic CLOCK,
    input wire logic RST_B,
    input wire logic [tank_bus_pkg::ADDR_W-1:0] REG_ADDR,
    input wire logic [tank_bus_pkg::DATA_W-1:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [tank_bus_pkg::DATA_W-1:0] REG_RDATA,
    input wire logic POLL_VALID,
    input wire logic [6:0] POLL_ADDR,
    input wire logic COMM_ERROR,
    input wire logic [tank_bus_pkg::ITEM_N*tank_bus_pkg::ITEM_W-1:0] ITEMS,
    output logic REPLY_VALID,
    output logic REPLY_LAST,
    output logic [6:0] REPLY_ADDR,
    output logic [15:0] REPLY_LEVEL,
    output logic [15:0] REPLY_TEMP,
    output logic RELAY_CLOSE,
    output logic BUS_ENABLE,
    output logic XCVR_TEST_START,
    input wire logic XCVR_TEST_DONE,
    input wire logic XCVR_TEST_PASS,
    output logic IRQ
);
    import tank_bus_pkg::*;

    function automatic logic signed [23:0] item_at(
        input logic [ITEM_N*ITEM_W-1:0] items,
        input logic [2:0] idx);
        item_at = items[idx*ITEM_W +: ITEM_W];
    endfunction

    // Negative levels clamp to zero, overrange to the top code
    function automatic logic [15:0] encode_level(
        input logic signed [23:0] raw,
        input logic [1:0] kind);
        logic [23:0] mag;
        logic [23:0] q;
        logic [23:0] lim;
        mag = raw[23] ? 24'h00_0000 : raw;
        case (kind)
            ENC_COARSE: begin
                q = mag / DIV_COARSE;
                lim = MAX_COARSE;
            end
            ENC_TYPE4: begin
                q = mag / DIV_TYPE4;
                lim = MAX_TYPE4;
            end
            default: begin
                q = mag / DIV_FINE;
                lim = MAX_FINE;
            end
        endcase
        encode_level = (q > lim) ? lim[15:0] : q[15:0];
    endfunction

    function automatic logic [15:0] encode_temp(
        input logic signed [23:0] raw);
        logic signed [23:0] q;
        q = raw / TEMP_DIV;
        if (q > TEMP_MAX) begin
            q = TEMP_MAX;
        end else if (q < -TEMP_MAX) begin
            q = -TEMP_MAX;
        end
        encode_temp = q[15:0];
    endfunction

    logic [1:0] enc_type;
    logic [1:0] unit_pairs;
    logic [6:0] unit_addr;
    logic [6:0] second_reply_addr;
    logic [6:0] third_reply_addr;
    logic [2:0] second_level_source;
    logic [2:0] second_temperature_source;
    logic [2:0] third_level_source;
    logic [2:0] third_temperature_source;
    logic [15:0] resp_delay;
    logic [3:0] irq_enable;
    logic [3:0] irq_status;
    logic [3:0] irq_events;
    logic [2:0] poll_seen;
    logic [6:0] last_poll_addr;
    logic [15:0] err_count;
    logic [15:0] poll_count;
    link_state_t bus_link_state;
    reply_state_t reply_state;
    logic [1:0] match;
    logic [1:0] reply_kind;
    logic [1:0] send_idx;
    logic [1:0] send_total;
    logic [15:0] ticks_left;
    logic [15:0] div_cnt;
    logic done_sync1;
    logic done_sync2;
    logic done_prev;
    logic pass_sync1;
    logic pass_sync2;
    logic test_done;
    logic poll_taken;
    logic wr_cmd;

    assign wr_cmd = REG_WR && (REG_ADDR == REG_COMMAND);
    assign test_done = done_sync2 && !done_prev;

    always_comb begin
        if (POLL_ADDR == unit_addr) begin
            match = MATCH_UNIT;
        end else if (second_reply_addr != 7'h00 &&
                     POLL_ADDR == second_reply_addr) begin
            match = MATCH_SECOND;
        end else if (third_reply_addr != 7'h00 &&
                     POLL_ADDR == third_reply_addr) begin
            match = MATCH_THIRD;
        end else begin
            match = MATCH_NONE;
        end
    end

    assign poll_taken = POLL_VALID && (match != MATCH_NONE) &&
                        (bus_link_state == LINK_CONNECTED);

    // Configuration registers
    always_ff @(posedge CLOCK) begin
        if (!RST_B) begin
            enc_type <= ENC_FINE;
            unit_pairs <= PAIRS_RST;
            unit_addr <= UNIT_ADDR_RST;
            second_reply_addr <= EXTRA_ADDR_RST;
            third_reply_addr <= EXTRA_ADDR_RST;
            second_level_source <= 3'h0;
            second_temperature_source <= 3'h0;
            third_level_source <= 3'h0;
            third_temperature_source <= 3'h0;
            resp_delay <= RESP_DELAY_RST;
            irq_enable <= 4'h0;
        end else if (REG_WR) begin
            case (REG_ADDR)
                REG_CTRL: begin
                    enc_type <= REG_WDATA[1:0];
                    unit_pairs <= REG_WDATA[3:2];
                end
                REG_UNIT_ADDR: unit_addr <= REG_WDATA[6:0];
                REG_SECOND_ADDR: second_reply_addr <= REG_WDATA[6:0];
                REG_THIRD_ADDR: third_reply_addr <= REG_WDATA[6:0];
                REG_SOURCES: begin
                    second_level_source <= REG_WDATA[2:0];
                    second_temperature_source <= REG_WDATA[6:4];
                    third_level_source <= REG_WDATA[10:8];
                    third_temperature_source <= REG_WDATA[14:12];
                end
                REG_RESP_DELAY: resp_delay <= REG_WDATA[15:0];
                REG_IRQ_ENABLE: irq_enable <= REG_WDATA[3:0];
                default: begin
                end
            endcase
        end
    end

    // Test result lines come from the transceiver, not this clock
    always_ff @(posedge CLOCK) begin
        if (!RST_B) begin
            done_sync1 <= 1'b0;
            done_sync2 <= 1'b0;
            done_prev <= 1'b0;
            pass_sync1 <= 1'b0;
            pass_sync2 <= 1'b0;
        end else begin
            done_sync1 <= XCVR_TEST_DONE;
            done_sync2 <= done_sync1;
            done_prev <= done_sync2;
            pass_sync1 <= XCVR_TEST_PASS;
            pass_sync2 <= pass_sync1;
        end
    end

    // Bus link state and relay
    always_ff @(posedge CLOCK) begin
        if (!RST_B) begin
            bus_link_state <= LINK_CONNECTED;
            RELAY_CLOSE <= 1'b1;
            BUS_ENABLE <= 1'b1;
            XCVR_TEST_START <= 1'b0;
        end else begin
            XCVR_TEST_START <= 1'b0;
            case (bus_link_state)
                LINK_CONNECTED: begin
                    if (wr_cmd && REG_WDATA[CMD_TEST]) begin
                        bus_link_state <= LINK_TEST_OPEN;
                        RELAY_CLOSE <= 1'b0;
                        BUS_ENABLE <= 1'b0;
                    end else if (wr_cmd && REG_WDATA[CMD_ISOLATE]) begin
                        bus_link_state <= LINK_ISOLATED;
                        RELAY_CLOSE <= 1'b0;
                        BUS_ENABLE <= 1'b0;
                    end
                end
                LINK_ISOLATED: begin
                    if (wr_cmd && REG_WDATA[CMD_TEST]) begin
                        bus_link_state <= LINK_TEST_OPEN;
                    end else if (wr_cmd && REG_WDATA[CMD_CONNECT]) begin
                        bus_link_state <= LINK_CONNECTED;
                        RELAY_CLOSE <= 1'b1;
                        BUS_ENABLE <= 1'b1;
                    end
                end
                LINK_TEST_OPEN: begin
                    bus_link_state <= LINK_TEST_RUN;
                    XCVR_TEST_START <= 1'b1;
                end
                LINK_TEST_RUN: begin
                    if (test_done && pass_sync2) begin
                        bus_link_state <= LINK_CONNECTED;
                        RELAY_CLOSE <= 1'b1;
                        BUS_ENABLE <= 1'b1;
                    end else if (test_done) begin
                        bus_link_state <= LINK_ISOLATED;
                    end
                end
                default: bus_link_state <= LINK_ISOLATED;
            endcase
        end
    end

    // Reply sequencer; polls arriving while busy are dropped
    always_ff @(posedge CLOCK) begin
        if (!RST_B) begin
            reply_state <= RS_IDLE;
            reply_kind <= MATCH_NONE;
            REPLY_ADDR <= 7'h00;
            send_idx <= 2'h0;
            send_total <= 2'h0;
            ticks_left <= 16'h0000;
            div_cnt <= 16'h0000;
        end else begin
            case (reply_state)
                RS_IDLE: begin
                    if (poll_taken) begin
                        reply_state <= RS_WAIT;
                        reply_kind <= match;
                        REPLY_ADDR <= POLL_ADDR;
                        send_idx <= 2'h0;
                        if (match != MATCH_UNIT) begin
                            send_total <= 2'h1;
                        end else if (unit_pairs == 2'h0) begin
                            send_total <= 2'h1;
                        end else begin
                            send_total <= unit_pairs;
                        end
                        ticks_left <= resp_delay;
                        div_cnt <= 16'h0000;
                    end
                end
                RS_WAIT: begin
                    if (bus_link_state != LINK_CONNECTED) begin
                        reply_state <= RS_IDLE;
                    end else if (ticks_left == 16'h0000) begin
                        reply_state <= RS_SEND;
                    end else if (div_cnt == 16'(TICK_CYCLES - 1)) begin
                        div_cnt <= 16'h0000;
                        ticks_left <= ticks_left - 16'h0001;
                    end else begin
                        div_cnt <= div_cnt + 16'h0001;
                    end
                end
                RS_SEND: begin
                    if (send_idx == send_total - 2'h1 ||
                        bus_link_state != LINK_CONNECTED) begin
                        reply_state <= RS_IDLE;
                    end
                    send_idx <= send_idx + 2'h1;
                end
                default: reply_state <= RS_IDLE;
            endcase
        end
    end

    // Reply pair outputs
    always_ff @(posedge CLOCK) begin
        if (!RST_B) begin
            REPLY_VALID <= 1'b0;
            REPLY_LAST <= 1'b0;
            REPLY_LEVEL <= 16'h0000;
            REPLY_TEMP <= 16'h0000;
        end else if (reply_state == RS_SEND &&
                     bus_link_state == LINK_CONNECTED) begin
            REPLY_VALID <= 1'b1;
            REPLY_LAST <= (send_idx == send_total - 2'h1);
            case (reply_kind)
                MATCH_SECOND: begin
                    REPLY_LEVEL <= encode_level(
                        item_at(ITEMS, second_level_source), enc_type);
                    REPLY_TEMP <= encode_temp(
                        item_at(ITEMS, second_temperature_source));
                end
                MATCH_THIRD: begin
                    REPLY_LEVEL <= encode_level(
                        item_at(ITEMS, third_level_source), enc_type);
                    REPLY_TEMP <= encode_temp(
                        item_at(ITEMS, third_temperature_source));
                end
                default: begin
                    // Unit pairs: level item n, temperature item n+4
                    REPLY_LEVEL <= encode_level(
                        item_at(ITEMS, {1'b0, send_idx}), enc_type);
                    REPLY_TEMP <= encode_temp(
                        item_at(ITEMS, {1'b1, send_idx}));
                end
            endcase
        end else begin
            REPLY_VALID <= 1'b0;
            REPLY_LAST <= 1'b0;
        end
    end

    // Counters and poll address tracking
    always_ff @(posedge CLOCK) begin
        if (!RST_B) begin
            err_count <= 16'h0000;
            poll_count <= 16'h0000;
            poll_seen <= 3'h0;
            last_poll_addr <= 7'h00;
        end else begin
            if (REG_WR && REG_ADDR == REG_ERR_COUNT) begin
                err_count <= 16'h0000;
            end else if (COMM_ERROR && bus_link_state == LINK_CONNECTED &&
                         err_count != 16'hFFFF) begin
                err_count <= err_count + 16'h0001;
            end
            if (REG_WR && REG_ADDR == REG_POLL_COUNT) begin
                poll_count <= 16'h0000;
            end else if (poll_taken && poll_count != 16'hFFFF) begin
                poll_count <= poll_count + 16'h0001;
            end
            // polled address set, read clears, new poll wins
            if (poll_taken) begin
                poll_seen <= ((REG_RD && REG_ADDR == REG_POLL_ADDRS) ?
                    3'h0 : poll_seen) | (3'h1 << (match - 2'h1));
                last_poll_addr <= POLL_ADDR;
            end else if (REG_RD && REG_ADDR == REG_POLL_ADDRS) begin
                poll_seen <= 3'h0;
            end
        end
    end

    // Interrupt status: a new event wins over a clear in the same cycle
    assign irq_events = {test_done && bus_link_state == LINK_TEST_RUN &&
                             !pass_sync2,
                         test_done && bus_link_state == LINK_TEST_RUN &&
                             pass_sync2,
                         COMM_ERROR && bus_link_state == LINK_CONNECTED,
                         poll_taken};

    always_ff @(posedge CLOCK) begin
        if (!RST_B) begin
            irq_status <= 4'h0;
            IRQ <= 1'b0;
        end else begin
            if (REG_WR && REG_ADDR == REG_IRQ_CLEAR) begin
                irq_status <= (irq_status & ~REG_WDATA[3:0]) | irq_events;
            end else begin
                irq_status <= irq_status | irq_events;
            end
            IRQ <= |(irq_status & irq_enable);
        end
    end

    // Read port: data valid only in the cycle after the strobe
    always_ff @(posedge CLOCK) begin
        if (!RST_B || !REG_RD) begin
            REG_RDATA <= 32'h0000_0000;
        end else begin
            case (REG_ADDR)
                REG_CTRL: REG_RDATA <= {28'h000_0000, unit_pairs, enc_type};
                REG_UNIT_ADDR: REG_RDATA <= {25'h000_0000, unit_addr};
                REG_SECOND_ADDR: REG_RDATA <= {25'h000_0000,
                                               second_reply_addr};
                REG_THIRD_ADDR: REG_RDATA <= {25'h000_0000, third_reply_addr};
                REG_SOURCES: REG_RDATA <= {17'h0_0000,
                    third_temperature_source, 1'b0, third_level_source, 1'b0,
                    second_temperature_source, 1'b0, second_level_source};
                REG_RESP_DELAY: REG_RDATA <= {16'h0000, resp_delay};
                REG_LINK_STATUS: REG_RDATA <= {28'h000_0000, BUS_ENABLE,
                                               RELAY_CLOSE, bus_link_state};
                REG_POLL_ADDRS: REG_RDATA <= {17'h0_0000, last_poll_addr,
                                              5'h00, poll_seen};
                REG_ERR_COUNT: REG_RDATA <= {16'h0000, err_count};
                REG_POLL_COUNT: REG_RDATA <= {16'h0000, poll_count};
                REG_IRQ_STATUS: REG_RDATA <= {28'h000_0000, irq_status};
                REG_IRQ_ENABLE: REG_RDATA <= {28'h000_0000, irq_enable};
                default: REG_RDATA <= 32'h0000_0000;
            endcase
        end
    end
endmodule

// >>> logic/tank_bus_pkg.sv
// Constants, register map and state types of the tank bus responder.
// Assumes a 50 MHz system clock and a plain strobe register port.
package tank_bus_pkg;
    localparam int CLOCK_HZ = 32'h02FA_F080;
    localparam int TICK_US = 32'h0000_0064;
    localparam int TICK_CYCLES_DEF = CLOCK_HZ / 32'h000F_4240 * TICK_US;
    localparam int RESP_DELAY_MS = 32'h0000_0002;
    localparam logic [15:0] RESP_DELAY_RST =
        16'(RESP_DELAY_MS * 32'h0000_03E8 / TICK_US);

    localparam int ADDR_W = 5;
    localparam int DATA_W = 32;
    localparam int ITEM_W = 24;
    localparam int ITEM_N = 8;

    localparam logic [4:0] REG_CTRL = 5'h00;
    localparam logic [4:0] REG_UNIT_ADDR = 5'h01;
    localparam logic [4:0] REG_SECOND_ADDR = 5'h02;
    localparam logic [4:0] REG_THIRD_ADDR = 5'h03;
    localparam logic [4:0] REG_SOURCES = 5'h04;
    localparam logic [4:0] REG_RESP_DELAY = 5'h05;
    localparam logic [4:0] REG_COMMAND = 5'h06;
    localparam logic [4:0] REG_LINK_STATUS = 5'h07;
    localparam logic [4:0] REG_POLL_ADDRS = 5'h08;
    localparam logic [4:0] REG_ERR_COUNT = 5'h09;
    localparam logic [4:0] REG_POLL_COUNT = 5'h0A;
    localparam logic [4:0] REG_IRQ_STATUS = 5'h0B;
    localparam logic [4:0] REG_IRQ_CLEAR = 5'h0C;
    localparam logic [4:0] REG_IRQ_ENABLE = 5'h0D;

    localparam logic [6:0] UNIT_ADDR_RST = 7'h01;
    localparam logic [6:0] EXTRA_ADDR_RST = 7'h00;
    localparam logic [1:0] PAIRS_RST = 2'h1;
    localparam logic [1:0] PAIRS_MAX = 2'h3;

    localparam int CMD_ISOLATE = 0;
    localparam int CMD_CONNECT = 1;
    localparam int CMD_TEST = 2;

    localparam int IRQ_POLL = 0;
    localparam int IRQ_ERROR = 1;
    localparam int IRQ_TEST_PASS = 2;
    localparam int IRQ_TEST_FAIL = 3;

    localparam logic [1:0] ENC_FINE = 2'h0;
    localparam logic [1:0] ENC_COARSE = 2'h1;
    localparam logic [1:0] ENC_TYPE4 = 2'h2;
    localparam logic [23:0] DIV_FINE = 24'h00_000A;
    localparam logic [23:0] DIV_COARSE = 24'h00_0014;
    localparam logic [23:0] DIV_TYPE4 = 24'h00_0003;
    localparam logic [23:0] MAX_FINE = 24'h00_2580;
    localparam logic [23:0] MAX_COARSE = 24'h00_31FB;
    localparam logic [23:0] MAX_TYPE4 = 24'h00_DE36;
    localparam logic signed [23:0] TEMP_DIV = 24'sh00_0064;
    localparam logic signed [23:0] TEMP_MAX = 24'sh00_1FFE;

    localparam logic [1:0] MATCH_NONE = 2'h0;
    localparam logic [1:0] MATCH_UNIT = 2'h1;
    localparam logic [1:0] MATCH_SECOND = 2'h2;
    localparam logic [1:0] MATCH_THIRD = 2'h3;

    typedef enum logic [1:0] {
        LINK_CONNECTED = 2'b00,
        LINK_ISOLATED = 2'b01,
        LINK_TEST_OPEN = 2'b10,
        LINK_TEST_RUN = 2'b11
    } link_state_t;

    typedef enum logic [1:0] {
        RS_IDLE = 2'b00,
        RS_WAIT = 2'b01,
        RS_SEND = 2'b10
    } reply_state_t;
endpackage

// >>> tb/tank_bus_responder_assertions.sv
// Port-level checks of the tank bus responder.
// Assumes one clock and the synchronous active-low reset.
`timescale 1ns/1ps
module tank_bus_checker #(
    parameter int TICK_CYCLES = tank_bus_pkg::TICK_CYCLES_DEF
) (
    input wire logic CLOCK,
    input wire logic RST_B,
    input wire logic [tank_bus_pkg::ADDR_W-1:0] REG_ADDR,
    input wire logic [tank_bus_pkg::DATA_W-1:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REPLY_VALID,
    input wire logic REPLY_LAST,
    input wire logic RELAY_CLOSE,
    input wire logic BUS_ENABLE,
    input wire logic XCVR_TEST_START,
    input wire logic XCVR_TEST_DONE,
    input wire logic XCVR_TEST_PASS
);
    import tank_bus_pkg::*;
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RST_B);
    logic cmd;
    logic linked;
    assign cmd = REG_WR && REG_ADDR == REG_COMMAND && linked;
    assign linked = RELAY_CLOSE && BUS_ENABLE;
    sequence s_open;
        !RELAY_CLOSE && !BUS_ENABLE && !XCVR_TEST_START;
    endsequence
    sequence s_run;
        XCVR_TEST_START && !BUS_ENABLE;
    endsequence
    AST_ISOLATE:
    assert property (cmd && REG_WDATA[2:0] == 3'h1 |=> s_open)
        else $error("isolate did not open the relay");
    AST_TEST_SEQ:
    assert property (cmd && REG_WDATA[2] |=> s_open ##1 s_run)
        else $error("self-test did not leave the bus first");
    AST_TEST_PULSE:
    assert property (XCVR_TEST_START |=> !XCVR_TEST_START && !linked)
        else $error("test start not a single pulse");
    AST_TEST_PASS:
    assert property ($rose(XCVR_TEST_DONE) && XCVR_TEST_PASS
        |-> ##[2:8] linked) else $error("no reconnect after pass");
    AST_TEST_FAIL:
    assert property ($rose(XCVR_TEST_DONE) && !XCVR_TEST_PASS
        |-> (!RELAY_CLOSE && !BUS_ENABLE)[*8]) else $error("fail rejoined");
    AST_SILENT:
    assert property (!BUS_ENABLE && !$past(BUS_ENABLE) |-> !REPLY_VALID)
        else $error("reply while off the bus");
    AST_PAIR_MAX:
    assert property (REPLY_VALID ##1 REPLY_VALID ##1 REPLY_VALID
        |-> REPLY_LAST) else $error("more than three pairs");
    AST_PAIR_RUN:
    assert property (REPLY_VALID && !REPLY_LAST |=> REPLY_VALID)
        else $error("gap inside a reply");
endmodule
bind tank_bus_responder tank_bus_checker #(.TICK_CYCLES(TICK_CYCLES)) chk (
    .CLOCK(CLOCK), .RST_B(RST_B), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REPLY_VALID(REPLY_VALID),
    .REPLY_LAST(REPLY_LAST), .RELAY_CLOSE(RELAY_CLOSE),
    .BUS_ENABLE(BUS_ENABLE), .XCVR_TEST_START(XCVR_TEST_START),
    .XCVR_TEST_DONE(XCVR_TEST_DONE), .XCVR_TEST_PASS(XCVR_TEST_PASS));

// >>> tb/xcvr_model.sv
// Transceiver self-test responder.
// Assumes start is a one-cycle pulse; result and latency set by the bench.
`timescale 1ns/1ps
module xcvr_model (
    input wire logic clk,
    input wire logic start,
    input wire logic good,
    input wire logic [3:0] lat,
    output logic done,
    output logic pass
);
    initial begin
        done = 1'b0;
        pass = 1'b0;
    end
    // Result shows the wrong level until it is valid
    always @(posedge clk) begin
        if (start) begin
            done <= 1'b0;
            pass <= ~good;
            repeat (lat) @(posedge clk);
            pass <= good;
            @(posedge clk);
            done <= 1'b1;
        end
    end
endmodule

// >>> tb/tank_bus_responder_tb.sv
// Self-checking bench of the tank bus responder.
// Assumes the checker binds itself; the model answers self-tests.
`timescale 1ns/1ps
module tank_bus_responder_tb;
    import tank_bus_pkg::*;
    localparam int TK = 5;
    logic CLOCK = 1'b0;
    logic RST_B = 1'b0;
    logic [4:0] REG_ADDR = 5'h0;
    logic [31:0] REG_WDATA = 32'h0, REG_RDATA;
    logic REG_WR = 1'b0, REG_RD = 1'b0, POLL_VALID = 1'b0, COMM_ERROR = 1'b0;
    logic [6:0] POLL_ADDR = 7'h0, REPLY_ADDR, a2;
    logic [191:0] ITEMS = '0;
    logic [15:0] REPLY_LEVEL, REPLY_TEMP, lv[4], tp[4];
    logic REPLY_VALID, REPLY_LAST, RELAY_CLOSE, BUS_ENABLE, IRQ, last;
    logic XCVR_TEST_START, XCVR_TEST_DONE, XCVR_TEST_PASS, good = 1'b1;
    logic [3:0] lat = 4'h1;
    logic [14:0] s;
    int num_errors = 0, cmp_count = 0, np, t0;
    tank_bus_responder #(.TICK_CYCLES(TK)) uut (.CLOCK(CLOCK),
        .RST_B(RST_B), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
        .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
        .POLL_VALID(POLL_VALID), .POLL_ADDR(POLL_ADDR), .ITEMS(ITEMS),
        .COMM_ERROR(COMM_ERROR), .REPLY_VALID(REPLY_VALID),
        .REPLY_LAST(REPLY_LAST), .REPLY_ADDR(REPLY_ADDR), .IRQ(IRQ),
        .REPLY_LEVEL(REPLY_LEVEL), .REPLY_TEMP(REPLY_TEMP),
        .RELAY_CLOSE(RELAY_CLOSE), .BUS_ENABLE(BUS_ENABLE),
        .XCVR_TEST_START(XCVR_TEST_START), .XCVR_TEST_DONE(XCVR_TEST_DONE),
        .XCVR_TEST_PASS(XCVR_TEST_PASS));
    xcvr_model rsp (.clk(CLOCK), .start(XCVR_TEST_START), .good(good),
        .lat(lat), .done(XCVR_TEST_DONE), .pass(XCVR_TEST_PASS));
    initial forever #10 CLOCK = ~CLOCK;
    function automatic logic [15:0] lvl(int r, int e);
        int dv, mx;
        dv = e == 1 ? DIV_COARSE : e == 2 ? DIV_TYPE4 : DIV_FINE;
        mx = e == 1 ? MAX_COARSE : e == 2 ? MAX_TYPE4 : MAX_FINE;
        r = r / dv;
        return 16'(r < 0 ? 0 : r > mx ? mx : r);
    endfunction
    function automatic logic [15:0] tmp(int r);
        r = r / 100;
        return 16'(r < -TEMP_MAX ? -TEMP_MAX : r > TEMP_MAX ? TEMP_MAX : r);
    endfunction
    function automatic int item(int n);
        return int'($signed(ITEMS[24*n +: 24]));
    endfunction
    task automatic end_sim();
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            $display("wrong value %s expected %h seen %h", n, e, g);
            num_errors++;
        end
    endtask
    task automatic wr(logic [4:0] a, logic [31:0] v);
        @(posedge CLOCK);
        REG_ADDR <= a;
        REG_WDATA <= v;
        REG_WR <= 1'b1;
        @(posedge CLOCK);
        REG_WR <= 1'b0;
    endtask
    task automatic rd(logic [4:0] a, logic [31:0] e, string n);
        @(posedge CLOCK);
        REG_ADDR <= a;
        REG_RD <= 1'b1;
        @(posedge CLOCK);
        REG_RD <= 1'b0;
        #1 chk(n, e, REG_RDATA);
    endtask
    // Extreme items drive both level clamps and the low temperature clamp
    task automatic rnd(bit c);
        @(posedge CLOCK);
        for (int n = 0; n < 8; n++)
            ITEMS[24*n +: 24] <= c ? (n == 0 ? 24'h7F_FFFF : 24'h80_0000)
                : 24'($urandom_range(32'h0003_A980) - 32'h0000_9C40);
    endtask
    task automatic poll(logic [6:0] a);
        @(posedge CLOCK);
        POLL_ADDR <= a;
        POLL_VALID <= 1'b1;
        @(posedge CLOCK);
        POLL_VALID <= 1'b0;
        np = 0;
        t0 = 0;
        for (int i = 1; i < 120; i++) begin
            #1;
            if (REPLY_VALID === 1'b1 && np < 4) begin
                if (np == 0) t0 = i;
                lv[np] = REPLY_LEVEL;
                tp[np] = REPLY_TEMP;
                last = REPLY_LAST;
                np++;
            end
            @(posedge CLOCK);
        end
    endtask
    task automatic unit_chk(int n, int k, int t);
        chk("pairs", n, np);
        chk("delay", t, t0);
        chk("last", 1, last);
        for (int p = 0; p < n; p++) begin
            chk("level", lvl(item(p), k), lv[p]);
            chk("temp", tmp(item(p + 4)), tp[p]);
        end
    endtask
    initial begin
        repeat (20000) @(posedge CLOCK);
        num_errors++;
        end_sim();
    end
    initial begin
        void'($urandom(27642));
        repeat (10) @(posedge CLOCK);
        RST_B <= 1'b1;
        rd(REG_SECOND_ADDR, 32'h0, "second");
        rd(REG_THIRD_ADDR, 32'h0, "third");
        rd(REG_RESP_DELAY, 32'h14, "delay");
        rd(REG_LINK_STATUS, 32'hC, "link");
        rd(5'h1F, 32'h0, "unmapped");
        rnd(0);
        poll(7'h01);
        unit_chk(1, 0, int'(RESP_DELAY_RST) * TK + 3);
        wr(REG_RESP_DELAY, 32'h0);
        for (int k = 0; k < 4; k++) begin
            rnd(k == 3);
            wr(REG_CTRL, 32'hC | 32'(k));
            poll(7'h01);
            unit_chk(3, k, 3);
        end
        $display("test unit replies done");
        rnd(0);
        a2 = 7'($urandom_range(63, 2));
        s = 15'($urandom) & 15'h7777;
        wr(REG_SECOND_ADDR, 32'(a2));
        wr(REG_THIRD_ADDR, 32'(a2 + 7'h40));
        wr(REG_SOURCES, 32'(s));
        for (int j = 0; j < 2; j++) begin
            poll(a2 + 7'(64 * j));
            chk("extra pairs", 1, np);
            chk("addr", 32'(a2 + 7'(64 * j)), REPLY_ADDR);
            chk("extra level", lvl(item(s[8*j +: 3]), 3), lv[0]);
            chk("extra temp", tmp(item(s[8*j+4 +: 3])), tp[0]);
        end
        rd(REG_POLL_COUNT, 32'h7, "polls");
        rd(REG_POLL_ADDRS, {17'h0, a2 + 7'h40, 8'h07}, "polled");
        repeat (3) begin
            @(posedge CLOCK);
            COMM_ERROR <= 1'b1;
            @(posedge CLOCK);
            COMM_ERROR <= 1'b0;
        end
        rd(REG_ERR_COUNT, 32'h3, "errors");
        chk("irq masked", 0, IRQ);
        wr(REG_IRQ_ENABLE, 32'h2);
        repeat (2) @(posedge CLOCK);
        #1 chk("irq", 1, IRQ);
        wr(REG_IRQ_CLEAR, 32'hF);
        repeat (2) @(posedge CLOCK);
        #1 chk("irq cleared", 0, IRQ);
        wr(REG_SECOND_ADDR, 32'h0);
        poll(a2);
        chk("disabled", 0, np);
        poll(7'h00);
        chk("foreign", 0, np);
        $display("test extra and counters done");
        wr(REG_COMMAND, 32'h1);
        rd(REG_LINK_STATUS, 32'h1, "isolated");
        poll(7'h01);
        chk("isolated reply", 0, np);
        wr(REG_COMMAND, 32'h2);
        rd(REG_LINK_STATUS, 32'hC, "connected");
        for (int p = 1; p >= 0; p--) begin
            good <= p[0];
            lat <= p ? 4'h1 : 4'h9;
            wr(REG_COMMAND, 32'h4);
            repeat (20) @(posedge CLOCK);
            rd(REG_LINK_STATUS, p ? 32'hC : 32'h1, "test");
        end
        $display("test link done");
        end_sim();
    end
endmodule
